// ---- verilog/hcrb_defs.svh ----
// offsets, field positions and reset values of the hub configuration bank
// assumes: included by bare name from design files under verilog/
`ifndef HCRB_DEFS_SVH
`define HCRB_DEFS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define HCRB_ADDR_CTRL 8'h00
`define HCRB_ADDR_VEND_LO 8'h01
`define HCRB_ADDR_CFG1 8'h07
`define HCRB_ADDR_CFG2 8'h08
`define HCRB_LOCK_LO 8'h01
`define HCRB_LOCK_HI 8'h10
`define HCRB_MEM_WORDS 8

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define HCRB_CTRL_SRST 2
`define HCRB_CTRL_LOCK 1
`define HCRB_CTRL_ATTACH 0
`define HCRB_CFG1_PWR_SRC 7
`define HCRB_CFG1_LAMPS 6
`define HCRB_CFG1_FS_ONLY 5
`define HCRB_CFG1_TT_PORT 4
`define HCRB_CFG1_EOP_OFF 3
`define HCRB_CFG1_OC_HI 2
`define HCRB_CFG1_OC_LO 1
`define HCRB_CFG1_SUPPLY_SW 0
`define HCRB_CFG2_DYN 7
`define HCRB_RESET_VAL 8'h00

`endif

// ---- verilog/hcrb_pkg.sv ----
// types shared by the hub configuration bank
// assumes: compiled before every other design file
package hcrb_pkg;
	typedef logic [7:0] hcrb_byte_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_ACK = 7'h04,
		ST_RX = 7'h08,
		ST_TX = 7'h10,
		ST_RACK = 7'h20,
		ST_OFF = 7'h40
	} hcrb_state_t;
endpackage : hcrb_pkg

// ---- verilog/hcrb_reg_if.sv ----
// register access path between the serial engine and the memory bank
// assumes: one clock; all signals are driven by the modport owners
`timescale 1ns/100ps
`default_nettype none
interface hcrb_reg_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic lock;
	logic soft_clr;

	modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, lock, soft_clr, input rd_data);
	modport mem (input wr_en, wr_addr, wr_data, rd_addr, lock, soft_clr, output rd_data);
endinterface : hcrb_reg_if
`default_nettype wire

// ---- verilog/hcrb_pin_sync.sv ----
// three-stage pin synchroniser; the output moves once stages two and three agree
// assumes: inputs are asynchronous pins, reset is already synchronised
`timescale 1ns/100ps
`default_nettype none
module hcrb_pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// pins in, clean levels out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	if (W < 1) begin : g_bad_width
		$error("hcrb_pin_sync: W must be at least 1");
	end

	logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;

	always_comb begin
		q_nxt = q_r;
		for (int i = 0; i < W; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				q_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q_r <= RST_VAL;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= q_nxt;
		end
	end

	assign q_o = q_r;
endmodule : hcrb_pin_sync
`default_nettype wire

// ---- verilog/hcrb_cfg_mem.sv ----
// identity bytes and configuration bytes at 01h..08h
// assumes: writes arrive only after a completed write-byte transfer
`timescale 1ns/100ps
`default_nettype none
`include "hcrb_defs.svh"
module hcrb_cfg_mem
	import hcrb_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// register path
	hcrb_reg_if.mem bus,
	// stored values
	output logic [15:0] vendor_code_o,
	output logic [15:0] product_code_o,
	output logic [15:0] release_code_o,
	output logic [7:0] cfg1_o,
	output logic dyn_power_en_o
);
	hcrb_byte_t mem_r [`HCRB_MEM_WORDS];
	hcrb_byte_t mem_nxt [`HCRB_MEM_WORDS];
	logic [7:0] widx8, ridx8;
	logic wr_hit, rd_hit;

	assign widx8 = bus.wr_addr - `HCRB_ADDR_VEND_LO;
	assign ridx8 = bus.rd_addr - `HCRB_ADDR_VEND_LO;
	assign wr_hit = bus.wr_addr >= `HCRB_ADDR_VEND_LO && bus.wr_addr <= `HCRB_ADDR_CFG2;
	assign rd_hit = bus.rd_addr >= `HCRB_ADDR_VEND_LO && bus.rd_addr <= `HCRB_ADDR_CFG2;

	always_comb begin
		mem_nxt = mem_r;
		if (bus.soft_clr) begin
			for (int i = 0; i < `HCRB_MEM_WORDS; i++) mem_nxt[i] = `HCRB_RESET_VAL;
		end else if (bus.wr_en && wr_hit && !bus.lock) begin
			mem_nxt[widx8[2:0]] = bus.wr_data;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < `HCRB_MEM_WORDS; i++) mem_r[i] <= `HCRB_RESET_VAL;
		end else begin
			mem_r <= mem_nxt;
		end
	end

	// unimplemented addresses 09h..10h read as zero
	assign bus.rd_data = rd_hit ? mem_r[ridx8[2:0]] : `HCRB_RESET_VAL;
	// low byte sits at the lower address
	assign vendor_code_o = {mem_r[1], mem_r[0]};
	assign product_code_o = {mem_r[3], mem_r[2]};
	assign release_code_o = {mem_r[5], mem_r[4]};
	assign cfg1_o = mem_r[6];
	assign dyn_power_en_o = mem_r[7][`HCRB_CFG2_DYN];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	a_lock_blocks: assert property (bus.lock && bus.wr_en && wr_hit && !bus.soft_clr
		|=> mem_r[$past(widx8[2:0])] == $past(mem_r[widx8[2:0]]))
		else $error("locked write changed memory");
	a_write_takes: assert property (!bus.lock && bus.wr_en && wr_hit && !bus.soft_clr
		|=> mem_r[$past(widx8[2:0])] == $past(bus.wr_data))
		else $error("unlocked write not stored");
	a_soft_clear: assert property (bus.soft_clr |=> vendor_code_o == 16'h0000
		&& cfg1_o == 8'h00 && !dyn_power_en_o)
		else $error("soft reset left memory set");
endmodule : hcrb_cfg_mem
`default_nettype wire

// ---- verilog/hcrb_hub_config_regs.sv ----
// hub configuration bank: serial slave engine, control/status byte, outputs
// assumes: host speaks write-byte and read-byte; slave address strap is static
//
// Contract
// - soft reset bit clears slave interface and configuration memory, self-clears.
// - while locked, writes to 01h..10h are refused; unlocked, writes to 01h..08h store.
// - lock and attach are set once and cleared only by the pin reset.
// - attach bit set signals attach toward the upstream host.
// - after the attach write completes the slave stays silent until the pin reset.
// - control, identity and first configuration bytes reset to zero.
// - vendor, product, release codes are low byte then high byte, 01h..06h.
// - configuration bit 7 picks bus power (0) or self power (1).
// - with dynamic switching on, the sense pin decides the power source.
// - configuration bit 6 reports indicator lamps present.
// - configuration bit 5 forces full-speed-only attachment.
// - configuration bit 4 gives one translator per port.
// - configuration bit 3 suppresses full-speed end-of-packet at EOF1.
// - sense field 00 ganged, 01 per port, 1x no overcurrent sensing.
// - configuration bit 0 picks ganged or per-port supply switching.
// - registers change only after a complete single write-byte transfer.
// - second configuration byte bit 7 enables dynamic power switching.
`timescale 1ns/100ps
`default_nettype none
`include "hcrb_defs.svh"
module hcrb_hub_config_regs
	import hcrb_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// serial slave pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oen_o,
	input wire logic [6:0] slave_addr_i,
	// power sense pin
	input wire logic local_supply_sense_pin_i,
	// identity values
	output logic [15:0] vendor_code_o,
	output logic [15:0] product_code_o,
	output logic [15:0] release_code_o,
	// control state
	output logic usb_attach_o,
	output logic config_lock_o,
	output logic smbus_active_o,
	// hub configuration
	output logic self_powered_o,
	output logic indicator_lamps_present_o,
	output logic full_speed_only_o,
	output logic translator_per_port_o,
	output logic frame_end_marker_off_o,
	output logic [1:0] overcurrent_sense_mode_o,
	output logic port_supply_switching_o,
	output logic dynamic_power_enable_o
);
	// ------------------------------------------------------------
	// reset release and pin sampling
	// ------------------------------------------------------------
	logic [1:0] rst_q_r;
	logic rstn;
	logic scl_s, sda_s, sense_s;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_q_r <= 2'h0;
		end else begin
			rst_q_r <= {rst_q_r[0], 1'b1};
		end
	end
	assign rstn = rst_q_r[1];

	// idle bus lines are high, so start from high to avoid a false start
	hcrb_pin_sync #(.W(3), .RST_VAL(3'h3)) u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn),
		.d_i({local_supply_sense_pin_i, sda_i, scl_i}),
		.q_o({sense_s, sda_s, scl_s})
	);

	// slave address strap is caught once after reset release
	logic [6:0] saddr_r, saddr_nxt;
	logic strap_done_r, strap_done_nxt;

	always_comb begin
		saddr_nxt = saddr_r;
		strap_done_nxt = 1'b1;
		if (!strap_done_r) saddr_nxt = slave_addr_i;
	end

	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			saddr_r <= 7'h00;
			strap_done_r <= 1'b0;
		end else begin
			saddr_r <= saddr_nxt;
			strap_done_r <= strap_done_nxt;
		end
	end

	// ------------------------------------------------------------
	// serial slave engine
	// ------------------------------------------------------------
	hcrb_reg_if reg_bus ();
	hcrb_state_t st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [1:0] phase_r, phase_nxt;
	hcrb_byte_t shift_r, shift_nxt, raddr_r, raddr_nxt, wdata_r, wdata_nxt;
	hcrb_byte_t rx_byte, rd_byte;
	logic scl_q_r, sda_q_r, oen_r, oen_nxt, ack_drv_r, ack_drv_nxt;
	logic is_read_r, is_read_nxt, wr_en_r, wr_en_nxt;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic lock_r, lock_nxt, attach_r, attach_nxt, srst_r, srst_nxt;

	assign scl_rise = scl_s & ~scl_q_r;
	assign scl_fall = ~scl_s & scl_q_r;
	assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign stop_det = scl_s & scl_q_r & ~sda_q_r & sda_s;
	assign rx_byte = {shift_r[6:0], sda_s};
	// reserved and self-clearing bits of the control byte read as zero
	assign rd_byte = (raddr_r == `HCRB_ADDR_CTRL) ?
		{6'h00, lock_r, attach_r} : reg_bus.rd_data;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		phase_nxt = phase_r;
		shift_nxt = shift_r;
		raddr_nxt = raddr_r;
		wdata_nxt = wdata_r;
		oen_nxt = oen_r;
		ack_drv_nxt = ack_drv_r;
		is_read_nxt = is_read_r;
		wr_en_nxt = 1'b0;
		if (attach_r) begin
			st_nxt = ST_OFF;
			oen_nxt = 1'b1;
		end else if (srst_r) begin
			st_nxt = ST_IDLE;
			phase_nxt = 2'h0;
			oen_nxt = 1'b1;
			is_read_nxt = 1'b0;
		end else if (start_det && st_r != ST_OFF) begin
			st_nxt = ST_ADDR;
			cnt_nxt = 4'h0;
			oen_nxt = 1'b1;
			is_read_nxt = 1'b0;
			// only a restart right after the register address survives
			if (phase_r != 2'h2) phase_nxt = 2'h0;
		end else if (stop_det && st_r != ST_OFF) begin
			if (phase_r == 2'h3 && !is_read_r) wr_en_nxt = 1'b1;
			st_nxt = ST_IDLE;
			phase_nxt = 2'h0;
			oen_nxt = 1'b1;
		end else begin
			unique case (st_r)
				ST_IDLE, ST_OFF: begin
				end
				ST_ADDR: if (scl_rise) begin
					shift_nxt = rx_byte;
					cnt_nxt = cnt_r + 4'h1;
					if (cnt_r == 4'h7) begin
						st_nxt = ST_IDLE;
						if (rx_byte[7:1] == saddr_r && rx_byte[7:1] != 7'h00) begin
							if (!rx_byte[0] && phase_r == 2'h0) begin
								phase_nxt = 2'h1;
								st_nxt = ST_ACK;
							end else if (rx_byte[0] && phase_r == 2'h2) begin
								is_read_nxt = 1'b1;
								st_nxt = ST_ACK;
							end
						end
					end
				end
				ST_ACK: if (scl_fall) begin
					if (!ack_drv_r) begin
						oen_nxt = 1'b0;
						ack_drv_nxt = 1'b1;
					end else begin
						ack_drv_nxt = 1'b0;
						cnt_nxt = 4'h0;
						if (is_read_r) begin
							st_nxt = ST_TX;
							oen_nxt = rd_byte[7];
							shift_nxt = {rd_byte[6:0], 1'b0};
							cnt_nxt = 4'h1;
						end else begin
							st_nxt = ST_RX;
							oen_nxt = 1'b1;
						end
					end
				end
				ST_RX: if (scl_rise) begin
					shift_nxt = rx_byte;
					cnt_nxt = cnt_r + 4'h1;
					if (cnt_r == 4'h7) begin
						st_nxt = ST_ACK;
						if (phase_r == 2'h1) begin
							raddr_nxt = rx_byte;
							phase_nxt = 2'h2;
						end else if (phase_r == 2'h2) begin
							wdata_nxt = rx_byte;
							phase_nxt = 2'h3;
						end else begin
							// a second data byte is not a write-byte transfer
							st_nxt = ST_IDLE;
							phase_nxt = 2'h0;
						end
					end
				end
				ST_TX: if (scl_fall) begin
					if (cnt_r == 4'h8) begin
						oen_nxt = 1'b1;
						st_nxt = ST_RACK;
					end else begin
						oen_nxt = shift_r[7];
						shift_nxt = {shift_r[6:0], 1'b0};
						cnt_nxt = cnt_r + 4'h1;
					end
				end
				ST_RACK: if (scl_rise) begin
					st_nxt = ST_IDLE;
					phase_nxt = 2'h0;
				end
				default: begin
					st_nxt = ST_IDLE;
					oen_nxt = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			st_r <= ST_IDLE;
			cnt_r <= 4'h0;
			phase_r <= 2'h0;
			shift_r <= 8'h00;
			raddr_r <= 8'h00;
			wdata_r <= 8'h00;
			oen_r <= 1'b1;
			ack_drv_r <= 1'b0;
			is_read_r <= 1'b0;
			wr_en_r <= 1'b0;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			phase_r <= phase_nxt;
			shift_r <= shift_nxt;
			raddr_r <= raddr_nxt;
			wdata_r <= wdata_nxt;
			oen_r <= oen_nxt;
			ack_drv_r <= ack_drv_nxt;
			is_read_r <= is_read_nxt;
			wr_en_r <= wr_en_nxt;
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
		end
	end

	// ------------------------------------------------------------
	// control and status byte
	// ------------------------------------------------------------
	always_comb begin
		lock_nxt = lock_r;
		attach_nxt = attach_r;
		srst_nxt = 1'b0;
		// no lock check here so reset and attach stay usable
		if (wr_en_r && raddr_r == `HCRB_ADDR_CTRL) begin
			// bits 7:3 are simply not stored
			if (wdata_r[`HCRB_CTRL_SRST]) srst_nxt = 1'b1;
			if (wdata_r[`HCRB_CTRL_LOCK]) lock_nxt = 1'b1;
			if (wdata_r[`HCRB_CTRL_ATTACH]) attach_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			lock_r <= 1'b0;
			attach_r <= 1'b0;
			srst_r <= 1'b0;
		end else begin
			lock_r <= lock_nxt;
			attach_r <= attach_nxt;
			srst_r <= srst_nxt;
		end
	end

	assign reg_bus.wr_en = wr_en_r;
	assign reg_bus.wr_addr = raddr_r;
	assign reg_bus.wr_data = wdata_r;
	assign reg_bus.rd_addr = raddr_r;
	assign reg_bus.lock = lock_r;
	assign reg_bus.soft_clr = srst_r;

	// ------------------------------------------------------------
	// configuration memory and decoded outputs
	// ------------------------------------------------------------
	logic [7:0] cfg1;
	logic dyn_en, selfp_r, selfp_nxt;

	hcrb_cfg_mem u_mem (
		.clk_i(clk_i),
		.rstn_i(rstn),
		.bus(reg_bus),
		.vendor_code_o(vendor_code_o),
		.product_code_o(product_code_o),
		.release_code_o(release_code_o),
		.cfg1_o(cfg1),
		.dyn_power_en_o(dyn_en)
	);

	// dynamic switching follows the sensed supply, not the select bit
	always_comb selfp_nxt = dyn_en ? sense_s : cfg1[`HCRB_CFG1_PWR_SRC];

	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) selfp_r <= 1'b0;
		else selfp_r <= selfp_nxt;
	end

	assign self_powered_o = selfp_r;
	assign indicator_lamps_present_o = cfg1[`HCRB_CFG1_LAMPS];
	assign full_speed_only_o = cfg1[`HCRB_CFG1_FS_ONLY];
	assign translator_per_port_o = cfg1[`HCRB_CFG1_TT_PORT];
	assign frame_end_marker_off_o = cfg1[`HCRB_CFG1_EOP_OFF];
	assign overcurrent_sense_mode_o = cfg1[`HCRB_CFG1_OC_HI:`HCRB_CFG1_OC_LO];
	assign port_supply_switching_o = cfg1[`HCRB_CFG1_SUPPLY_SW];
	assign dynamic_power_enable_o = dyn_en;
	assign usb_attach_o = attach_r;
	assign config_lock_o = lock_r;
	assign smbus_active_o = st_r != ST_OFF;
	// open drain: the line is only ever pulled low
	assign sda_o = 1'b0;
	assign sda_oen_o = oen_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn);

	sequence s_ctrl_wr;
		wr_en_r && raddr_r == `HCRB_ADDR_CTRL;
	endsequence
	sequence s_attach_wr;
		s_ctrl_wr ##0 wdata_r[`HCRB_CTRL_ATTACH];
	endsequence
	sequence s_srst_wr;
		s_ctrl_wr ##0 wdata_r[`HCRB_CTRL_SRST];
	endsequence

	a_attach_silent: assert property (s_attach_wr |=> attach_r ##1
		(st_r == ST_OFF && sda_oen_o))
		else $error("attach did not shut the slave down");
	a_off_stays: assert property (st_r == ST_OFF |=> st_r == ST_OFF && sda_oen_o)
		else $error("slave woke after attach");
	a_lock_sticky: assert property (lock_r |=> lock_r)
		else $error("lock bit cleared without pin reset");
	a_attach_sticky: assert property (attach_r |=> attach_r)
		else $error("attach bit cleared without pin reset");
	a_ctrl_writable: assert property (s_ctrl_wr ##0 wdata_r[`HCRB_CTRL_LOCK]
		|=> lock_r)
		else $error("control write refused");
	a_srst_pulse: assert property (s_srst_wr |=> srst_r ##1 (!srst_r && st_r == ST_IDLE
		|| attach_r))
		else $error("soft reset not a single pulse");
	a_commit_stop: assert property (wr_en_r |-> $past(stop_det) && $past(phase_r) == 2'h3)
		else $error("write committed outside a completed transfer");
	a_power_pick: assert property ((dyn_en && $stable(sense_s)) [*2] |-> selfp_r == sense_s)
		else $error("power source ignores sense pin");
endmodule : hcrb_hub_config_regs
`default_nettype wire

// ---- testbench/hcrb_host_model.sv ----
// serial host model: byte write and byte read transfers on an open-drain line
// assumes: the bench forms the line level from all enables, with a pull-up
`timescale 1ns/100ps
`default_nettype none
module hcrb_host_model (
	// clock
	input wire logic clk_i,
	// serial lines
	input wire logic sda_line_i,
	output logic scl_o,
	output logic sda_oen_o
);
	// ------------------------------------------------------------
	// bit level
	// ------------------------------------------------------------
	initial begin
		scl_o = 1'b1;
		sda_oen_o = 1'b1;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_n
	// data moves well inside the low phase so it never looks like start or stop
	task automatic put_bit(input logic b, output logic seen);
		wait_n(2);
		sda_oen_o <= b;
		wait_n(6);
		scl_o <= 1'b1;
		wait_n(8);
		seen = sda_line_i;
		scl_o <= 1'b0;
	endtask : put_bit
	task automatic start;
		wait_n(2);
		sda_oen_o <= 1'b1;
		// a restart follows an ack that the slave drops late, so keep the low phase full
		wait_n(6);
		scl_o <= 1'b1;
		wait_n(8);
		sda_oen_o <= 1'b0;
		wait_n(8);
		scl_o <= 1'b0;
	endtask : start
	task automatic stop;
		wait_n(2);
		sda_oen_o <= 1'b0;
		wait_n(6);
		scl_o <= 1'b1;
		wait_n(8);
		sda_oen_o <= 1'b1;
		wait_n(8);
	endtask : stop
	// ------------------------------------------------------------
	// byte level, msb first
	// ------------------------------------------------------------
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], s);
		end
		put_bit(1'b1, s);
		ack = !s;
	endtask : send_byte
	task automatic recv_byte(output logic [7:0] d, input logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, s);
			d[i] = s;
		end
		put_bit(nack, s);
	endtask : recv_byte
	// complete write-byte transfer only; aborted ones are built by the bench
	task automatic write_byte(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
		output logic ok);
		logic k1, k2, k3;
		start();
		send_byte({a, 1'b0}, k1);
		send_byte(r, k2);
		send_byte(d, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask : write_byte
	task automatic read_byte(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d,
		output logic ok);
		logic k1, k2, k3;
		start();
		send_byte({a, 1'b0}, k1);
		send_byte(r, k2);
		start();
		send_byte({a, 1'b1}, k3);
		recv_byte(d, 1'b1);
		stop();
		ok = k1 & k2 & k3;
	endtask : read_byte
endmodule : hcrb_host_model
`default_nettype wire

// ---- testbench/test_hub_config_register_bank.sv ----
// self-checking bench of the hub configuration bank through its serial slave
// assumes: host model on the far side; sda pulled up when nobody drives it
`timescale 1ns/100ps
`default_nettype none
module test_hub_config_register_bank;
	localparam logic [6:0] ADDR = 7'h2C;
	localparam int LIMIT = 80000;
	logic clk, rstn, sense;
	wire logic scl, host_oen, dut_sda, dut_oen, sda_line;
	wire logic attach, lock, active, selfp, lamps, fso, ttp, eop, psw, dyn;
	wire logic [1:0] oc;
	wire logic [15:0] ven, pro, rel;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	assign sda_line = host_oen & (dut_oen | dut_sda);
	hcrb_host_model u_host (.clk_i(clk), .sda_line_i(sda_line), .scl_o(scl),
		.sda_oen_o(host_oen));
	hcrb_hub_config_regs u_dut (.clk_i(clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda_line),
		.sda_o(dut_sda), .sda_oen_o(dut_oen), .slave_addr_i(ADDR),
		.local_supply_sense_pin_i(sense), .vendor_code_o(ven), .product_code_o(pro),
		.release_code_o(rel), .usb_attach_o(attach), .config_lock_o(lock),
		.smbus_active_o(active), .self_powered_o(selfp), .indicator_lamps_present_o(lamps),
		.full_speed_only_o(fso), .translator_per_port_o(ttp), .frame_end_marker_off_o(eop),
		.overcurrent_sense_mode_o(oc), .port_supply_switching_o(psw),
		.dynamic_power_enable_o(dyn));
	initial clk = 1'b0;
	always #50 clk = ~clk;
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] r, input logic [7:0] d, input logic eack);
		logic ok;
		u_host.write_byte(ADDR, r, d, ok);
		chk("write ack", {15'h0000, eack}, {15'h0000, ok});
	endtask : wr
	task automatic rd(input logic [7:0] r, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		u_host.read_byte(ADDR, r, d, ok);
		chk("read ack", 16'h0001, {15'h0000, ok});
		chk("read data", {8'h00, e}, {8'h00, d});
	endtask : rd
	function automatic logic [7:0] cfg_out();
		return {selfp, lamps, fso, ttp, eop, oc, psw};
	endfunction : cfg_out
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_values;
		for (int r = 0; r < 8; r++) begin
			rd(r[7:0], 8'h00);
		end
		chk("codes", 16'h0000, ven | pro | rel);
		chk("ctrl outputs", 16'h0001, {13'h0000, attach, lock, active});
	endtask : t_reset_values
	task automatic t_invalid;
		logic ok;
		wr(8'h01, 8'h11, 1'b1);
		u_host.write_byte(ADDR ^ 7'h01, 8'h01, 8'h22, ok);
		chk("foreign address ack", 16'h0000, {15'h0000, ok});
		u_host.write_byte(7'h00, 8'h01, 8'h33, ok);
		chk("general call ack", 16'h0000, {15'h0000, ok});
		u_host.start();
		u_host.send_byte({ADDR, 1'b0}, ok);
		u_host.send_byte(8'h01, ok);
		u_host.stop();
		chk("vendor after refused", 16'h0011, ven);
	endtask : t_invalid
	task automatic t_identity;
		for (int i = 1; i < 7; i++) begin
			wr(i[7:0], 8'h11 * i[7:0], 1'b1);
		end
		chk("vendor code", 16'h2211, ven);
		chk("product code", 16'h4433, pro);
		chk("release code", 16'h6655, rel);
		rd(8'h04, 8'h44);
	endtask : t_identity
	task automatic t_cfg_bits;
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			v = 8'h01 << i;
			wr(8'h07, v, 1'b1);
			chk("cfg outputs", {8'h00, v}, {8'h00, cfg_out()});
		end
		wr(8'h07, 8'h06, 1'b1);
		chk("sense mode", 16'h0003, {14'h0000, oc});
		rd(8'h07, 8'h06);
	endtask : t_cfg_bits
	task automatic t_dynamic;
		wr(8'h07, 8'h00, 1'b1);
		wr(8'h08, 8'h80, 1'b1);
		chk("dynamic enable", 16'h0001, {15'h0000, dyn});
		sense <= 1'b1;
		repeat (8) @(posedge clk);
		chk("self powered by pin", 16'h0001, {15'h0000, selfp});
		sense <= 1'b0;
		wr(8'h07, 8'h80, 1'b1);
		chk("select ignored", 16'h0000, {15'h0000, selfp});
		wr(8'h08, 8'h00, 1'b1);
		chk("select obeyed", 16'h0001, {15'h0000, selfp});
	endtask : t_dynamic
	task automatic t_soft_reset;
		wr(8'h00, 8'h04, 1'b1);
		// the clear pulse adds a clock, and self power follows the cleared byte one later
		repeat (2) @(posedge clk);
		chk("codes cleared", 16'h0000, ven | pro | rel);
		chk("cfg cleared", 16'h0000, {8'h00, cfg_out()});
		rd(8'h00, 8'h00);
	endtask : t_soft_reset
	task automatic t_lock;
		wr(8'h01, 8'hA5, 1'b1);
		wr(8'h07, 8'h10, 1'b1);
		wr(8'h00, 8'h02, 1'b1);
		chk("lock set", 16'h0001, {15'h0000, lock});
		wr(8'h01, 8'h5A, 1'b1);
		wr(8'h07, 8'h00, 1'b1);
		chk("locked vendor", 16'h00A5, ven);
		chk("locked cfg", 16'h0010, {8'h00, cfg_out()});
		wr(8'h00, 8'h00, 1'b1);
		rd(8'h00, 8'h02);
		wr(8'h00, 8'h04, 1'b1);
		chk("soft reset while locked", 16'h0000, ven);
		chk("lock kept", 16'h0001, {15'h0000, lock});
	endtask : t_lock
	task automatic t_attach;
		logic [7:0] d;
		logic ok;
		wr(8'h00, 8'h03, 1'b1);
		chk("attach", 16'h0001, {15'h0000, attach});
		chk("slave off", 16'h0000, {15'h0000, active});
		u_host.read_byte(ADDR, 8'h00, d, ok);
		chk("silent read", 16'h0000, {15'h0000, ok});
		wr(8'h00, 8'h00, 1'b0);
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (12) @(posedge clk);
		chk("after pin reset", 16'h0001, {13'h0000, attach, lock, active});
		rd(8'h00, 8'h00);
	endtask : t_attach
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		sense = 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (12) @(posedge clk);
		t_reset_values();
		t_invalid();
		t_identity();
		t_cfg_bits();
		t_dynamic();
		t_soft_reset();
		t_lock();
		t_attach();
		test_done();
	end
endmodule : test_hub_config_register_bank
`default_nettype wire
